/* File: pkg/adbs_regs.vh */
`ifndef ADBS_REGS_VH
`define ADBS_REGS_VH

// Register indices on the plain register port
`define ADBS_A_CTRL      4'h0
`define ADBS_A_CFG       4'h1
`define ADBS_A_ACC       4'h2
`define ADBS_A_PWR       4'h3
`define ADBS_A_TRK       4'h4
`define ADBS_A_RES_L     4'h5
`define ADBS_A_RES_H     4'h6
`define ADBS_A_GT_L      4'h7
`define ADBS_A_GT_H      4'h8
`define ADBS_A_LT_L      4'h9
`define ADBS_A_LT_H      4'ha
`define ADBS_A_STAT      4'hb

// Control register fields
`define ADBS_CTRL_EN     7
`define ADBS_CTRL_BURST  6
`define ADBS_CTRL_DONE   5
`define ADBS_CTRL_BUSY   4
`define ADBS_CTRL_WIN    3
`define ADBS_CTRL_SRC_HI 2
`define ADBS_CTRL_SRC_LO 0

// Start source codes
`define ADBS_SRC_SW      3'h0
`define ADBS_SRC_T0      3'h1
`define ADBS_SRC_T2      3'h2
`define ADBS_SRC_T3      3'h3

// Converter configuration fields
`define ADBS_CFG_DIV_HI  7
`define ADBS_CFG_DIV_LO  3
`define ADBS_CFG_8B      2
`define ADBS_CFG_DT      1
`define ADBS_CFG_GAIN    0

// Accumulator configuration fields
`define ADBS_ACC_12B     7
`define ADBS_ACC_RPT_HI  2
`define ADBS_ACC_RPT_LO  0

// Reset values
`define ADBS_CTRL_RST    8'h00
`define ADBS_CFG_RST     8'hf8
`define ADBS_ACC_RST     8'h00
`define ADBS_PWR_RST     4'hf
`define ADBS_TRK_RST     6'h1e

// Timing
`define ADBS_CLK_NS      40
`define ADBS_PWR_STEP_NS 400
`define ADBS_PWR_STEP_CYC ((`ADBS_PWR_STEP_NS + `ADBS_CLK_NS - 1) / `ADBS_CLK_NS)
`define ADBS_DLY_TRACK   7'h03

`endif

/* File: design/adbs_sar_core.v */
`timescale 1ns/1ns
`default_nettype none

module adbs_sar_core (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       tick,
  input  wire       start,
  input  wire       eight_bit,
  input  wire       cmp_above,
  output reg  [9:0] dac_code,
  output reg        done,
  output reg  [9:0] result
);

  reg  [9:0] mask_reg;
  reg        run_reg;
  wire [9:0] kept = cmp_above ? dac_code : (dac_code & ~mask_reg);
  wire [9:0] mask_next = {1'b0, mask_reg[9:1]};
  // 8-bit mode stops after bit 2, two bit clocks sooner
  wire       last = (mask_next == 10'h000) || (eight_bit && mask_reg == 10'h004);

  always @(posedge clk) begin
    if (sys_rst) begin
      dac_code <= 10'h000;
      mask_reg <= 10'h000;
      run_reg  <= 1'b0;
      done     <= 1'b0;
      result   <= 10'h000;
    end else begin
      done <= 1'b0;
      if (start) begin
        run_reg  <= 1'b1;
        mask_reg <= 10'h200;
        dac_code <= 10'h200;
      end else if (run_reg && tick) begin
        if (last) begin
          run_reg  <= 1'b0;
          done     <= 1'b1;
          result   <= kept;
          dac_code <= kept;
        end else begin
          mask_reg <= mask_next;
          dac_code <= kept | mask_next;
        end
      end
    end
  end

endmodule // adbs_sar_core

`default_nettype wire

/* File: design/adbs_sequencer.v */
`timescale 1ns/1ns
`default_nettype none
`include "adbs_regs.vh"

module adbs_sequencer (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       timer0_ovf,
  input  wire       timer2_ovf,
  input  wire       timer3_ovf,
  input  wire       ext_start_pin,
  input  wire       cmp_above,
  output reg        analog_power_on,
  output reg        track_on,
  output wire [9:0] dac_code,
  output reg  [1:0] ref_level_sel,
  output reg  [1:0] element_rotate,
  output reg        gain_half,
  output reg        conversion_done_flag,
  output reg        window_flag
);

  localparam S_IDLE  = 3'd0;
  localparam S_PWRUP = 3'd1;
  localparam S_TRACK = 3'd2;
  localparam S_CONV  = 3'd3;
  localparam S_WAIT  = 3'd4;
  localparam S_END   = 3'd5;

  // Software state
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  cfg_reg;
  reg  [7:0]  acc_cfg_reg;
  reg  [3:0]  pwr_reg;
  reg  [5:0]  trk_reg;
  reg  [15:0] gt_reg;
  reg  [15:0] lt_reg;
  reg  [15:0] result_reg;

  // Sequencer state
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [15:0] sum_reg;
  reg  [6:0]  count_reg;
  reg  [7:0]  pu_cnt_reg;
  reg  [6:0]  trk_cnt_reg;
  reg  [4:0]  div_cnt_reg;
  reg         conv_start_reg;
  reg         ext_s1_reg;
  reg         ext_s2_reg;
  reg         ext_s3_reg;

  wire        conv_en    = ctrl_reg[`ADBS_CTRL_EN];
  wire        burst_en   = ctrl_reg[`ADBS_CTRL_BURST];
  wire [2:0]  src_sel    = ctrl_reg[`ADBS_CTRL_SRC_HI:`ADBS_CTRL_SRC_LO];
  wire [4:0]  sar_div    = cfg_reg[`ADBS_CFG_DIV_HI:`ADBS_CFG_DIV_LO];
  wire        eight_bit  = cfg_reg[`ADBS_CFG_8B];
  wire        dly_track  = cfg_reg[`ADBS_CFG_DT];
  wire        twelve_bit = acc_cfg_reg[`ADBS_ACC_12B];
  wire [2:0]  rpt_code   = acc_cfg_reg[`ADBS_ACC_RPT_HI:`ADBS_ACC_RPT_LO];

  // Converter clock tick; in burst it is the block's own timebase, so a burst
  // completes with no help from software regardless of how slowly it runs
  wire        sar_tick   = (div_cnt_reg == 5'h00);

  // Repeat count decode; reserved codes fall back to a single conversion
  reg  [6:0]  rpt_target;
  always @* begin
    case (rpt_code)
      3'h0:    rpt_target = 7'd1;
      3'h1:    rpt_target = 7'd4;
      3'h2:    rpt_target = 7'd8;
      3'h3:    rpt_target = 7'd16;
      3'h4:    rpt_target = 7'd32;
      3'h5:    rpt_target = 7'd64;
      default: rpt_target = 7'd1;
    endcase
  end

  // Power-up delay in clock cycles, rounded up per 400 ns step
  wire [31:0] pu_full = ({28'h0, pwr_reg} + 32'h1) * `ADBS_PWR_STEP_CYC;
  wire [7:0]  pu_load = pu_full[7:0];

  // Tracking length in converter clocks
  wire [6:0]  dly_add   = dly_track ? `ADBS_DLY_TRACK : 7'h00;
  wire [6:0]  trk_load  = burst_en ? ({1'b0, trk_reg} + dly_add) : dly_add;

  // Start sources
  wire        sw_start  = reg_wr && (reg_addr == `ADBS_A_CTRL) &&
                          reg_wdata[`ADBS_CTRL_BUSY] && (src_sel == `ADBS_SRC_SW);
  wire        ext_rise  = ext_s2_reg && !ext_s3_reg;
  reg         start_req;
  always @* begin
    case (src_sel)
      `ADBS_SRC_SW: start_req = sw_start;
      `ADBS_SRC_T0: start_req = timer0_ovf;
      `ADBS_SRC_T2: start_req = timer2_ovf;
      `ADBS_SRC_T3: start_req = timer3_ovf;
      default:      start_req = ext_rise;
    endcase
  end

  // Starts are only taken when idle; the source is expected to space them
  wire        start_take = start_req && (state_reg == S_IDLE);

  wire        core_done;
  wire [9:0]  core_result;
  wire [15:0] sum_add    = sum_reg + {6'h00, core_result};
  wire [6:0]  count_inc  = count_reg + 7'd1;
  wire        series_end = (count_inc >= rpt_target);
  wire        in_window  = (sum_add >= gt_reg) && (sum_add <= lt_reg);

  adbs_sar_core u_core (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .tick      (sar_tick),
    .start     (conv_start_reg),
    .eight_bit (eight_bit),
    .cmp_above (cmp_above),
    .dac_code  (dac_code),
    .done      (core_done),
    .result    (core_result)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_take) begin
          if (burst_en && !analog_power_on)
            state_next = S_PWRUP;
          else if (trk_load != 7'h00)
            state_next = S_TRACK;
          else
            state_next = S_CONV;
        end
      end
      S_PWRUP: begin
        if (pu_cnt_reg == 8'h01)
          state_next = (trk_load != 7'h00) ? S_TRACK : S_CONV;
      end
      S_TRACK: begin
        if (sar_tick && trk_cnt_reg == 7'h01)
          state_next = S_CONV;
      end
      S_CONV: begin
        state_next = S_WAIT;
      end
      S_WAIT: begin
        if (core_done) begin
          if (series_end)
            state_next = S_END;
          else if (burst_en)
            state_next = (trk_load != 7'h00) ? S_TRACK : S_CONV;
          else
            state_next = S_IDLE;
        end
      end
      S_END: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Sequencer datapath
  always @(posedge clk) begin
    if (sys_rst) begin
      state_reg      <= S_IDLE;
      sum_reg        <= 16'h0000;
      count_reg      <= 7'h00;
      pu_cnt_reg     <= 8'h00;
      trk_cnt_reg    <= 7'h00;
      div_cnt_reg    <= 5'h00;
      conv_start_reg <= 1'b0;
      ext_s1_reg     <= 1'b0;
      ext_s2_reg     <= 1'b0;
      ext_s3_reg     <= 1'b0;
      result_reg     <= 16'h0000;
    end else begin
      state_reg      <= state_next;
      ext_s1_reg     <= ext_start_pin;
      ext_s2_reg     <= ext_s1_reg;
      ext_s3_reg     <= ext_s2_reg;
      conv_start_reg <= (state_next == S_CONV);
      div_cnt_reg    <= sar_tick ? sar_div : div_cnt_reg - 5'h01;
      if (state_reg == S_IDLE && start_take) begin
        pu_cnt_reg  <= pu_load;
        trk_cnt_reg <= trk_load;
        if (burst_en || count_reg == 7'h00) begin
          sum_reg   <= 16'h0000;
          count_reg <= 7'h00;
        end
      end
      if (state_reg == S_PWRUP && pu_cnt_reg != 8'h00)
        pu_cnt_reg <= pu_cnt_reg - 8'h01;
      if (state_reg == S_TRACK && sar_tick && trk_cnt_reg != 7'h00)
        trk_cnt_reg <= trk_cnt_reg - 7'h01;
      if (state_reg == S_WAIT && core_done) begin
        // Twelve-bit result is simply the running sum of the 10-bit results, as many as the repeat count sets
        sum_reg     <= sum_add;
        trk_cnt_reg <= trk_load;
        if (series_end) begin
          result_reg <= sum_add;
          count_reg  <= 7'h00;
        end else begin
          count_reg  <= count_inc;
        end
      end
    end
  end

  // Analog controls
  always @(posedge clk) begin
    if (sys_rst) begin
      analog_power_on <= 1'b0;
      track_on        <= 1'b0;
      ref_level_sel   <= 2'h0;
      element_rotate  <= 2'h0;
      gain_half       <= 1'b1;
    end else begin
      gain_half <= ~cfg_reg[`ADBS_CFG_GAIN];
      track_on  <= (state_next == S_TRACK) || (state_next == S_PWRUP);
      if (!burst_en)
        analog_power_on <= conv_en;
      else if (state_next != S_IDLE)
        analog_power_on <= 1'b1;
      else if (state_reg == S_END || state_reg == S_IDLE)
        analog_power_on <= conv_en;
      if (twelve_bit) begin
        ref_level_sel  <= count_reg[1:0];
        element_rotate <= count_reg[1:0] + 2'h1;
      end else begin
        ref_level_sel  <= 2'h0;
        element_rotate <= 2'h0;
      end
    end
  end

  // Flags: a hardware set wins over a software write in the same cycle
  wire done_set = (state_reg == S_WAIT) && core_done && series_end;
  wire win_set  = done_set && in_window;
  wire ctrl_wr  = reg_wr && (reg_addr == `ADBS_A_CTRL);

  always @(posedge clk) begin
    if (sys_rst) begin
      conversion_done_flag <= 1'b0;
      window_flag          <= 1'b0;
    end else begin
      if (done_set)
        conversion_done_flag <= 1'b1;
      else if (ctrl_wr)
        conversion_done_flag <= reg_wdata[`ADBS_CTRL_DONE];
      if (win_set)
        window_flag <= 1'b1;
      else if (ctrl_wr)
        window_flag <= reg_wdata[`ADBS_CTRL_WIN];
    end
  end

  // Register writes
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg    <= `ADBS_CTRL_RST;
      cfg_reg     <= `ADBS_CFG_RST;
      acc_cfg_reg <= `ADBS_ACC_RST;
      pwr_reg     <= `ADBS_PWR_RST;
      trk_reg     <= `ADBS_TRK_RST;
      gt_reg      <= 16'hffff;
      lt_reg      <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADBS_A_CTRL: ctrl_reg    <= {reg_wdata[7:6], 3'h0, reg_wdata[2:0]};
        `ADBS_A_CFG:  cfg_reg     <= reg_wdata;
        `ADBS_A_ACC:  acc_cfg_reg <= {reg_wdata[7], 4'h0, reg_wdata[2:0]};
        `ADBS_A_PWR:  pwr_reg     <= reg_wdata[3:0];
        `ADBS_A_TRK:  trk_reg     <= reg_wdata[5:0];
        `ADBS_A_GT_L: gt_reg[7:0]  <= reg_wdata;
        `ADBS_A_GT_H: gt_reg[15:8] <= reg_wdata;
        `ADBS_A_LT_L: lt_reg[7:0]  <= reg_wdata;
        `ADBS_A_LT_H: lt_reg[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  reg [7:0] rd_mux;
  always @* begin
    case (reg_addr)
      `ADBS_A_CTRL:  rd_mux = {ctrl_reg[7:6], conversion_done_flag,
                              (state_reg != S_IDLE), window_flag, ctrl_reg[2:0]};
      `ADBS_A_CFG:   rd_mux = cfg_reg;
      `ADBS_A_ACC:   rd_mux = acc_cfg_reg;
      `ADBS_A_PWR:   rd_mux = {4'h0, pwr_reg};
      `ADBS_A_TRK:   rd_mux = {2'h0, trk_reg};
      `ADBS_A_RES_L: rd_mux = eight_bit ? 8'h00 : result_reg[7:0];
      `ADBS_A_RES_H: rd_mux = result_reg[15:8];
      `ADBS_A_GT_L:  rd_mux = gt_reg[7:0];
      `ADBS_A_GT_H:  rd_mux = gt_reg[15:8];
      `ADBS_A_LT_L:  rd_mux = lt_reg[7:0];
      `ADBS_A_LT_H:  rd_mux = lt_reg[15:8];
      `ADBS_A_STAT:  rd_mux = {3'h0, analog_power_on, track_on, state_reg};
      default:       rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 8'h00;
  end

endmodule // adbs_sequencer

`default_nettype wire

/* File: tb/adbs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "adbs_regs.vh"

module adbs_checker (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       analog_power_on,
  input wire logic       track_on,
  input wire logic [1:0] ref_level_sel,
  input wire logic [1:0] element_rotate,
  input wire logic       gain_half,
  input wire logic       conversion_done_flag,
  input wire logic       window_flag
);
  logic       en_reg;
  logic       burst_reg;
  logic       eight_reg;
  logic       gain_reg;
  logic       dt_reg;
  logic       div0_reg;
  logic       pwr_d_reg;
  logic [3:0] pwr_reg;
  logic [9:0] pu_cnt_reg;

  // Shadow of the control bits, taken from the same writes the block sees
  always @(posedge clk) begin
    if (sys_rst) begin
      en_reg     <= 1'b0;
      burst_reg  <= 1'b0;
      eight_reg  <= 1'b0;
      gain_reg   <= 1'b0;
      dt_reg     <= 1'b0;
      div0_reg   <= 1'b0;
      pwr_reg    <= 4'hf;
      pwr_d_reg  <= 1'b0;
      pu_cnt_reg <= 10'h000;
    end else begin
      pwr_d_reg <= analog_power_on;
      if (reg_wr && reg_addr == `ADBS_A_CTRL) begin
        en_reg    <= reg_wdata[`ADBS_CTRL_EN];
        burst_reg <= reg_wdata[`ADBS_CTRL_BURST];
      end
      if (reg_wr && reg_addr == `ADBS_A_CFG) begin
        eight_reg <= reg_wdata[`ADBS_CFG_8B];
        gain_reg  <= reg_wdata[`ADBS_CFG_GAIN];
        dt_reg    <= reg_wdata[`ADBS_CFG_DT];
        div0_reg  <= (reg_wdata[`ADBS_CFG_DIV_HI:`ADBS_CFG_DIV_LO] == 5'h00);
      end
      if (reg_wr && reg_addr == `ADBS_A_PWR)
        pwr_reg <= reg_wdata[3:0];
      if (analog_power_on && !pwr_d_reg)
        pu_cnt_reg <= 10'h001;
      else if (track_on && pu_cnt_reg != 10'h3ff)
        pu_cnt_reg <= pu_cnt_reg + 10'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_hw_done;
    $rose(conversion_done_flag) && !$past(reg_wr);
  endsequence
  sequence s_sleep_mode;
    burst_reg && !en_reg;
  endsequence
  // With the divider at zero a converter clock is one clock
  sequence s_three_track;
    track_on [*3] ##1 !track_on;
  endsequence

  AST_BURST_SLEEP: assert property (s_hw_done ##0 s_sleep_mode |-> ##[0:3] !analog_power_on)
    else $error("converter left powered after burst");
  AST_BURST_AWAKE: assert property (burst_reg && en_reg && analog_power_on && !reg_wr |=> analog_power_on)
    else $error("converter powered down with enable set");
  AST_POWERUP: assert property ($fell(track_on) ##0 s_sleep_mode |-> pu_cnt_reg >= (pwr_reg + 1) * 10)
    else $error("power-up delay too short");
  AST_LOW_ZERO: assert property (reg_rd && reg_addr == `ADBS_A_RES_L && eight_reg |=> reg_rdata == 8'h00)
    else $error("low result byte not zero in 8-bit mode");
  AST_UNMAPPED: assert property (reg_rd && reg_addr >= 4'hc |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ROTATE: assert property (ref_level_sel != 2'b00 || element_rotate != 2'b00 |-> element_rotate == ref_level_sel + 2'b01)
    else $error("element rotation not tied to sub-conversion");
  AST_GAIN: assert property (reg_wr && reg_addr == `ADBS_A_CFG |-> ##2 gain_half == !gain_reg)
    else $error("gain select not followed");
  AST_CLEAR: assert property (reg_wr && reg_addr == `ADBS_A_CTRL && !reg_wdata[`ADBS_CTRL_DONE] && !track_on |=> !conversion_done_flag)
    else $error("done flag not cleared");
  AST_WIN: assert property ($rose(window_flag) && !$past(reg_wr) |-> conversion_done_flag)
    else $error("window flag on a partial sum");
  AST_DLY_TRACK: assert property ($rose(track_on) && !burst_reg && dt_reg && div0_reg |-> s_three_track)
    else $error("delayed tracking not three converter clocks");
endmodule // adbs_checker

bind adbs_sequencer adbs_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .analog_power_on(analog_power_on), .track_on(track_on), .ref_level_sel(ref_level_sel),
  .element_rotate(element_rotate), .gain_half(gain_half),
  .conversion_done_flag(conversion_done_flag), .window_flag(window_flag)
);
`default_nettype wire

/* File: tb/adbs_analog_model.sv */
`timescale 1ns/1ns
`default_nettype none

module adbs_analog_model (
  input  wire logic        clk,
  input  wire logic        analog_power_on,
  input  wire logic [9:0]  dac_code,
  input  wire logic [1:0]  ref_level_sel,
  input  wire logic        gain_half,
  input  wire logic [11:0] vin_q,
  output logic             cmp_above
);
  logic        junk_reg = 1'b0;
  logic [12:0] eff;

  always @(negedge clk) junk_reg <= ~junk_reg;
  // Input in quarter steps; each reference level lifts it one quarter
  assign eff = (gain_half ? {2'b00, vin_q[11:1]} : {1'b0, vin_q}) + {11'h000, ref_level_sel};
  // Unpowered comparator gives noise, never a stale decision
  // A trial code equal to the input counts as above it, so four shifted
  // sub-conversions add up to the input itself
  assign cmp_above = analog_power_on ? (eff >= {1'b0, dac_code, 2'b00}) : junk_reg;
endmodule // adbs_analog_model
`default_nettype wire

/* File: tb/tb_adbs_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "adbs_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, b); end end

module tb_adbs_sequencer;
  logic        clk, sys_rst, reg_wr, reg_rd, timer0_ovf, timer2_ovf, timer3_ovf;
  logic        ext_start_pin, cmp_above, analog_power_on, track_on, gain_half;
  logic        conversion_done_flag, window_flag;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  logic [9:0]  dac_code;
  logic [1:0]  ref_level_sel, element_rotate;
  logic [11:0] vin_q;
  logic [15:0] res;
  int          fails, n_compared, c;
  int          sh[7] = '{0, 2, 3, 4, 5, 6, 0};
  localparam logic [15:0] K = 16'h026d;

  adbs_sequencer dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_ovf(timer0_ovf),
    .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf), .ext_start_pin(ext_start_pin),
    .cmp_above(cmp_above), .analog_power_on(analog_power_on), .track_on(track_on),
    .dac_code(dac_code), .ref_level_sel(ref_level_sel), .element_rotate(element_rotate),
    .gain_half(gain_half), .conversion_done_flag(conversion_done_flag),
    .window_flag(window_flag));
  adbs_analog_model u_adc (.clk(clk), .analog_power_on(analog_power_on), .dac_code(dac_code),
    .ref_level_sel(ref_level_sel), .gain_half(gain_half), .vin_q(vin_q), .cmp_above(cmp_above));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #5 rv = reg_rdata;
  endtask

  task automatic kick(input int src);
    @(posedge clk);
    case (src)
      1: timer0_ovf <= 1'b1;
      2: timer2_ovf <= 1'b1;
      3: timer3_ovf <= 1'b1;
      default: ext_start_pin <= 1'b1;
    endcase
    @(posedge clk);
    {timer0_ovf, timer2_ovf, timer3_ovf} <= 3'b000;
    repeat (4) @(posedge clk);
    ext_start_pin <= 1'b0;
  endtask

  task automatic wait_done();
    for (int i = 0; i < 4000 && conversion_done_flag !== 1'b1; i++) @(negedge clk);
    rd(`ADBS_A_RES_H);
    res[15:8] = rv;
    rd(`ADBS_A_RES_L);
    res[7:0] = rv;
  endtask

  // One start, then result, window and clearing of the flags
  task automatic run(input logic [7:0] ctl, input logic [7:0] acc, input int src,
                     input logic [15:0] exp, input logic win);
    wr(`ADBS_A_ACC, acc);
    wr(`ADBS_A_CTRL, ctl);
    if (src == 0) wr(`ADBS_A_CTRL, ctl | 8'h10);
    else kick(src);
    wait_done();
    `CHK(conversion_done_flag, 1'b1)
    `CHK(res, exp)
    `CHK(window_flag, win)
    wr(`ADBS_A_CTRL, ctl);
    @(negedge clk);
    `CHK(conversion_done_flag, 1'b0)
  endtask

  task automatic t_reset();
    rd(`ADBS_A_CTRL); `CHK(rv, 8'h00)
    rd(`ADBS_A_CFG); `CHK(rv, 8'hf8)
    rd(`ADBS_A_PWR); `CHK(rv, 8'h0f)
    rd(`ADBS_A_TRK); `CHK(rv, 8'h1e)
    wr(4'hd, 8'hff);
    rd(4'hd); `CHK(rv, 8'h00)
    `CHK(gain_half, 1'b1)
    wr(`ADBS_A_CFG, 8'h01);
    wr(`ADBS_A_PWR, 8'h01);
    wr(`ADBS_A_TRK, 8'h00);
    `CHK(gain_half, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_bursts();
    for (c = 0; c < 7; c++) begin
      run((c == 3) ? 8'h44 : 8'h41, c[7:0], (c == 3) ? 4 : 1, K << sh[c], 1'b0);
      `CHK(analog_power_on, 1'b0)
    end
    run(8'hc2, 8'h00, 2, K, 1'b0);
    `CHK(analog_power_on, 1'b1)
    $display("test bursts done");
  endtask

  task automatic t_single();
    // Delayed tracking on, so every start first tracks three converter clocks
    wr(`ADBS_A_CFG, 8'h03);
    wr(`ADBS_A_ACC, 8'h01);
    wr(`ADBS_A_CTRL, 8'h80);
    for (c = 0; c < 4; c++) begin
      `CHK(conversion_done_flag, 1'b0)
      wr(`ADBS_A_CTRL, 8'h90);
      rv = 8'hff;
      for (int i = 0; i < 400 && rv[4] !== 1'b0; i++) rd(`ADBS_A_CTRL);
    end
    wait_done();
    `CHK(res, K << 2)
    wr(`ADBS_A_CTRL, 8'h80);
    wr(`ADBS_A_CFG, 8'h01);
    $display("test single done");
  endtask

  task automatic t_modes();
    wr(`ADBS_A_CFG, 8'h05);
    run(8'h40, 8'h00, 0, 16'h0200, 1'b0);
    wr(`ADBS_A_CFG, 8'h01);
    wr(`ADBS_A_GT_L, 8'h00);
    wr(`ADBS_A_GT_H, 8'h00);
    wr(`ADBS_A_LT_L, 8'hff);
    wr(`ADBS_A_LT_H, 8'hff);
    run(8'h43, 8'h81, 3, 16'h09b6, 1'b1);
    run(8'h41, 8'h83, 1, 16'h26d8, 1'b1);
    wr(`ADBS_A_CFG, 8'h00);
    run(8'h40, 8'h00, 0, 16'h0136, 1'b1);
    $display("test modes done");
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    {sys_rst, reg_wr, reg_rd, timer0_ovf, timer2_ovf, timer3_ovf, ext_start_pin} = 7'h40;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    vin_q = 12'h9b6;
    fails = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_bursts();
    t_single();
    t_modes();
    final_report();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #(40 * 90000);
    fails++;
    final_report();
  end
endmodule // tb_adbs_sequencer
`default_nettype wire
